// ==== pwr_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
// Function
// - stop mode halts the CPU but keeps its state and memories.
// - stop mode ends on I/O interrupt, supply warning or supply failure.
// - wake-up timer counts ring oscillator ticks of 125us, up to about 8s.
// - supply monitor always on in normal operation; only stop may disable it.
// - the stop monitor disable bit resets to 1.
// - disabled monitor in stop detects neither warning nor failure.
// - falling below power-on level always gives a power-on reset.
// - monitor is re-enabled before stop exit completes and code runs.
// - warning found on stop exit sets the supply warning flag.
// - failure found on stop exit puts the CPU into reset.
// - warning held for persist time sets the flag; interrupt if enabled.
// - supply failure resets CPU, turns regulator and crystal off, keeps SRAM.
// - after recovery and warm-up the CPU restarts at address 8000h.
// - below power-on level everything is off and held in reset.
// - failure monitor interval is always-on or 2^11, 2^12, 2^13 ticks.
// - each check runs two ticks, then one more before leaving reset.
// - other resets keep supplies on; release within 20 crystal cycles.
module pwr_sequencer #(
    parameter int WARM_CYC = pwr_seq_pkg::XTAL_WARM_CYC
) (
    // clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           rstn,
    // analog comparators and ring oscillator
    input  wire logic                           por_ok,
    input  wire logic                           above_reset,
    input  wire logic                           above_warning,
    input  wire logic                           ring_osc,
    // other reset and wake sources
    input  wire logic                           ext_reset_req,
    input  wire logic                           io_wake,
    // software control
    input  wire logic                           stop_req,
    input  wire logic                           mon_dis_wr,
    input  wire logic                           mon_dis_wdata,
    input  wire logic                           wake_timer_en,
    input  wire logic [pwr_seq_pkg::TMR_W-1:0]  wake_interval,
    input  wire logic [1:0]                     monitor_interval_sel,
    input  wire logic                           warning_int_en,
    input  wire logic                           warning_flag_clr,
    // status and control outputs
    output logic                                stop_monitor_disable,
    output logic                                supply_warning_flag,
    output logic                                warning_irq,
    output logic                                cpu_reset,
    output logic                                cpu_halt,
    output logic                                monitor_on,
    output logic                                regulator_on,
    output logic                                xtal_on,
    output logic                                sram_retain,
    output logic [15:0]                         resume_addr
);
    import pwr_seq_pkg::*;
    localparam logic [CNT_W-1:0] WARM_LAST = CNT_W'(WARM_CYC - 1);
    localparam logic [CNT_W-1:0] PERS_LAST = CNT_W'(WARN_PERSIST_CYC - 1);
    localparam logic [CNT_W-1:0] REL_LAST  = CNT_W'(RST_REL_CYC - SYNC_LAT_CYC);
    localparam logic [CNT_W-1:0] SETTLE    = CNT_W'(MON_SETTLE_CYC);
    typedef struct packed {
        pwr_state_t       st;
        logic [SY_N-1:0]  sy1;
        logic [SY_N-1:0]  sy2;
        logic [CNT_W-1:0] cnt;
        logic             tmr_load;
        logic             tmr_run;
        logic [TMR_W-1:0] tmr_limit;
        logic             mon_dis;
        logic             warn_flag;
        logic             warn_irq;
        logic             cpu_reset;
        logic             cpu_halt;
        logic             mon_on;
        logic             reg_on;
        logic             xtal_on;
        logic             sram_ret;
        logic [15:0]      resume_addr;
    } seq_state_t;
    localparam seq_state_t RESET_STATE = '{
        st: ST_OFF, mon_dis: 1'b1, cpu_reset: 1'b1,
        resume_addr: COLD_START_ADDR, default: '0};
    seq_state_t s_r, s_nxt;
    pwr_state_t nst;
    logic       por, rst_ok, wrn_ok, ext, io, stop_mon, tmr_fin;
    ring_tmr_if tmr ();
    ring_timer u_ring_timer (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .ring_osc (ring_osc),
        .tmr      (tmr.timer)
    );
    assign tmr.load  = s_r.tmr_load;
    assign tmr.run   = s_r.tmr_run;
    assign tmr.limit = s_r.tmr_limit;
    assign tmr_fin   = tmr.done && !s_r.tmr_load;
    assign por      = s_r.sy2[SY_POR];
    assign rst_ok   = s_r.sy2[SY_RST];
    assign wrn_ok   = s_r.sy2[SY_WRN];
    assign ext      = s_r.sy2[SY_EXT];
    assign io       = s_r.sy2[SY_IO];
    assign stop_mon = !s_r.mon_dis;
    assign stop_monitor_disable = s_r.mon_dis;
    assign supply_warning_flag  = s_r.warn_flag;
    assign warning_irq          = s_r.warn_irq;
    assign cpu_reset            = s_r.cpu_reset;
    assign cpu_halt             = s_r.cpu_halt;
    assign monitor_on           = s_r.mon_on;
    assign regulator_on         = s_r.reg_on;
    assign xtal_on              = s_r.xtal_on;
    assign sram_retain          = s_r.sram_ret;
    assign resume_addr          = s_r.resume_addr;

    // ==========================================================
    // next state
    always_comb begin
        s_nxt          = s_r;
        nst            = s_r.st;
        s_nxt.tmr_load = 1'b0;
        // two-flop synchronisers for the comparator, reset and wake inputs; ring_osc is synchronised in ring_timer
        s_nxt.sy1 = {io_wake, ext_reset_req, above_warning,
                     above_reset, por_ok};
        s_nxt.sy2 = s_r.sy1;
        if (s_r.cnt != '1) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
        if (mon_dis_wr) begin
            s_nxt.mon_dis = mon_dis_wdata;
        end
        if (warning_flag_clr) begin
            s_nxt.warn_flag = 1'b0;
        end
        unique case (s_r.st)
            ST_OFF:       nst = ST_WARM;
            ST_WARM: begin
                if (s_r.cnt >= WARM_LAST && rst_ok) begin
                    nst = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!rst_ok) begin
                    nst = ST_PF_WAIT;
                end else if (ext) begin
                    nst = ST_EXT_RST;
                end else if (stop_req) begin
                    nst = ST_STOP;
                end else if (wrn_ok) begin
                    s_nxt.cnt = '0;
                end else if (s_r.cnt == PERS_LAST) begin
                    s_nxt.warn_flag = 1'b1;
                end
            end
            ST_STOP: begin
                if (stop_mon && !rst_ok) begin
                    nst = ST_PF_WAIT;
                end else if (ext) begin
                    nst = ST_EXT_RST;
                end else if ((stop_mon && !wrn_ok) || io ||
                             (s_r.tmr_run && tmr_fin)) begin
                    nst = ST_STOP_EXIT;
                end
            end
            ST_STOP_EXIT: begin
                if (s_r.cnt >= WARM_LAST && s_r.cnt >= SETTLE) begin
                    if (!rst_ok) begin
                        nst = ST_PF_WAIT;
                    end else begin
                        nst = ST_RUN;
                        if (!wrn_ok) begin
                            s_nxt.warn_flag = 1'b1;
                        end
                    end
                end
            end
            ST_PF_WAIT: begin
                if (monitor_interval_sel == MON_ALWAYS || tmr_fin) begin
                    nst = ST_PF_CHECK;
                end
            end
            ST_PF_CHECK: begin
                if (s_r.cnt >= SETTLE && !rst_ok) begin
                    nst = ST_PF_WAIT;
                end else if (tmr_fin) begin
                    nst = ST_WARM;
                    s_nxt.resume_addr = PF_RESUME_ADDR;
                end
            end
            ST_EXT_RST: begin
                if (!rst_ok) begin
                    nst = ST_PF_WAIT;
                end else if (ext) begin
                    s_nxt.cnt = '0;
                end else if (s_r.cnt >= REL_LAST) begin
                    nst = ST_RUN;
                end
            end
        endcase
        if (!por) begin
            nst = ST_OFF;
            s_nxt.resume_addr = COLD_START_ADDR;
        end
        if (nst != s_r.st) begin
            s_nxt.st       = nst;
            s_nxt.cnt      = '0;
            s_nxt.tmr_load = 1'b1;
        end
        // ring timer use per state
        s_nxt.tmr_run   = 1'b0;
        s_nxt.tmr_limit = CHECK_TICKS;
        if (nst == ST_STOP) begin
            s_nxt.tmr_run   = wake_timer_en && (wake_interval != '0);
            s_nxt.tmr_limit = wake_interval;
        end else if (nst == ST_PF_WAIT) begin
            s_nxt.tmr_run   = 1'b1;
            s_nxt.tmr_limit = (monitor_interval_sel == MON_2E11) ? TICKS_2E11 :
                              (monitor_interval_sel == MON_2E12) ? TICKS_2E12 :
                              TICKS_2E13;
        end else if (nst == ST_PF_CHECK) begin
            s_nxt.tmr_run   = 1'b1;
        end
        // supplies and CPU controls follow the coming state
        s_nxt.cpu_reset = nst inside {ST_OFF, ST_WARM, ST_PF_WAIT,
                                      ST_PF_CHECK, ST_EXT_RST};
        s_nxt.cpu_halt  = nst inside {ST_STOP, ST_STOP_EXIT};
        s_nxt.reg_on    = nst inside {ST_WARM, ST_RUN, ST_STOP_EXIT,
                                      ST_EXT_RST};
        s_nxt.xtal_on   = s_nxt.reg_on;
        s_nxt.sram_ret  = nst inside {ST_STOP, ST_STOP_EXIT, ST_PF_WAIT,
                                      ST_PF_CHECK};
        if (nst == ST_OFF) begin
            s_nxt.mon_on = 1'b0;
        end else if (nst == ST_STOP) begin
            s_nxt.mon_on = !s_nxt.mon_dis;
        end else if (nst == ST_PF_WAIT) begin
            s_nxt.mon_on = (monitor_interval_sel == MON_ALWAYS);
        end else begin
            s_nxt.mon_on = 1'b1;
        end
        s_nxt.warn_irq = s_nxt.warn_flag && warning_int_en;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= RESET_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end
    // ==========================================================
    // checks
    chk_por_forces_off: assert property (@(posedge sys_clk)
        disable iff (!rstn) !por |=> (s_r.st == ST_OFF && !s_r.reg_on &&
        !s_r.xtal_on && !s_r.mon_on && s_r.cpu_reset))
        else $error("power-on loss did not force full reset");
    chk_stop_halts_cpu: assert property (@(posedge sys_clk)
        disable iff (!rstn) s_r.st == ST_STOP |->
        (s_r.cpu_halt && !s_r.cpu_reset && s_r.sram_ret))
        else $error("stop mode lost cpu state");
    chk_stop_ignores_mon: assert property (@(posedge sys_clk)
        disable iff (!rstn) (s_r.st == ST_STOP && s_r.mon_dis && por)
        |=> s_r.st != ST_PF_WAIT)
        else $error("disabled monitor caused failure reset");
    chk_monitor_in_run: assert property (@(posedge sys_clk)
        disable iff (!rstn) s_r.st == ST_RUN |-> s_r.mon_on)
        else $error("monitor off in normal operation");
    chk_warn_persist: assert property (@(posedge sys_clk)
        disable iff (!rstn) ($rose(s_r.warn_flag) &&
        $past(s_r.st) == ST_RUN) |-> $past(s_r.cnt) == PERS_LAST)
        else $error("warning flag set before persist time");
    chk_pf_supplies_off: assert property (@(posedge sys_clk)
        disable iff (!rstn) s_r.st == ST_PF_WAIT |->
        (s_r.cpu_reset && !s_r.reg_on && !s_r.xtal_on && s_r.sram_ret))
        else $error("failure reset state wrong");
    chk_pf_resume_addr: assert property (@(posedge sys_clk)
        disable iff (!rstn) (s_r.st == ST_PF_CHECK && por)
        ##1 s_r.st == ST_WARM |-> s_r.resume_addr == PF_RESUME_ADDR)
        else $error("recovery address wrong");
    chk_warm_hold: assert property (@(posedge sys_clk)
        disable iff (!rstn) ($fell(s_r.cpu_reset) &&
        $past(s_r.st) == ST_WARM) |-> $past(s_r.cnt) >= WARM_LAST)
        else $error("reset released before warm-up");
    chk_ext_release: assert property (@(posedge sys_clk)
        disable iff (!rstn) (s_r.st == ST_EXT_RST && !ext && rst_ok &&
        por && s_r.cnt >= REL_LAST) |=> (!s_r.cpu_reset && s_r.reg_on))
        else $error("other reset not released in time");
    chk_exit_to_reset: assert property (@(posedge sys_clk)
        disable iff (!rstn) (s_r.st == ST_STOP_EXIT && s_r.cnt >= WARM_LAST
        && s_r.cnt >= SETTLE && !rst_ok && por) |=>
        (s_r.st == ST_PF_WAIT && s_r.cpu_reset))
        else $error("failure on stop exit did not reset");
    chk_exit_monitor: assert property (@(posedge sys_clk)
        disable iff (!rstn) s_r.st == ST_STOP_EXIT |-> s_r.mon_on)
        else $error("monitor not enabled on stop exit");
    chk_check_not_short: assert property (@(posedge sys_clk)
        disable iff (!rstn) (s_r.st == ST_PF_CHECK && s_r.tmr_load) |=>
        s_r.st != ST_WARM) else $error("recovery check window skipped");
endmodule // pwr_sequencer
`default_nettype wire

// ==== pwr_seq_pkg.sv ====
`default_nettype none
package pwr_seq_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_PS   = 8000;
    localparam int XTAL_PERIOD_PS  = 83333;
    localparam int XTAL_WARM_XTAL  = 8192;
    localparam int XTAL_WARM_CYC   =
        (XTAL_WARM_XTAL * XTAL_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RST_REL_XTAL    = 20;
    localparam int RST_REL_CYC     =
        (RST_REL_XTAL * XTAL_PERIOD_PS) / CLK_PERIOD_PS;
    localparam int SYNC_LAT_CYC    = 4;  // pin change to registered reaction
    localparam int WARN_PERSIST_NS = 10000;
    localparam int WARN_PERSIST_CYC =
        (WARN_PERSIST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MON_SETTLE_CYC  = 4;
    localparam int CNT_W           = 20;
    // ==========================================================
    // ring oscillator tick counts
    localparam int TMR_W                  = 16;
    localparam logic [TMR_W-1:0] TICKS_2E11   = 16'h0800;
    localparam logic [TMR_W-1:0] TICKS_2E12   = 16'h1000;
    localparam logic [TMR_W-1:0] TICKS_2E13   = 16'h2000;
    localparam logic [TMR_W-1:0] CHECK_TICKS  = 16'h0003;
    localparam logic [1:0]       MON_ALWAYS   = 2'h0;
    localparam logic [1:0]       MON_2E11     = 2'h1;
    localparam logic [1:0]       MON_2E12     = 2'h2;
    // ==========================================================
    // restart addresses and synchroniser lanes
    localparam logic [15:0] PF_RESUME_ADDR  = 16'h8000;
    localparam logic [15:0] COLD_START_ADDR = 16'h0000;
    localparam int SY_N   = 5;
    localparam int SY_POR = 0;
    localparam int SY_RST = 1;
    localparam int SY_WRN = 2;
    localparam int SY_EXT = 3;
    localparam int SY_IO  = 4;
    typedef enum logic [2:0] {
        ST_OFF, ST_WARM, ST_RUN, ST_STOP,
        ST_STOP_EXIT, ST_PF_WAIT, ST_PF_CHECK, ST_EXT_RST
    } pwr_state_t;
endpackage
`default_nettype wire

// ==== ring_tmr_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ring_tmr_if;
    import pwr_seq_pkg::*;
    logic             load;
    logic             run;
    logic [TMR_W-1:0] limit;
    logic             done;
    modport ctrl  (output load, output run, output limit, input done);
    modport timer (input load, input run, input limit, output done);
endinterface
`default_nettype wire

// ==== ring_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module ring_timer (
    // clock and reset
    input  wire logic    sys_clk,
    input  wire logic    rstn,
    // ring oscillator pin
    input  wire logic    ring_osc,
    // control from sequencer
    ring_tmr_if.timer    tmr
);
    import pwr_seq_pkg::*;
    typedef struct packed {
        logic [2:0]       sy;
        logic [TMR_W-1:0] cnt;
        logic             done;
    } tmr_state_t;
    tmr_state_t s_r, s_nxt;
    logic       rise;

    assign rise     = s_r.sy[1] & ~s_r.sy[2];
    assign tmr.done = s_r.done;

    // ==========================================================
    // tick counter
    always_comb begin
        s_nxt       = s_r;
        s_nxt.sy[0] = ring_osc;
        s_nxt.sy[1] = s_r.sy[0];
        s_nxt.sy[2] = s_r.sy[1];
        if (tmr.load) begin
            s_nxt.cnt  = '0;
            s_nxt.done = 1'b0;
        end else if (tmr.run && rise && !s_r.done) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
            if (s_nxt.cnt == tmr.limit) begin
                s_nxt.done = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule // ring_timer
`default_nettype wire

// ==== supply_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module supply_model #(
    parameter int POR_MV  = 1500,
    parameter int RST_MV  = 1700,
    parameter int WRN_MV  = 1900,
    parameter int RING_NS = 34
) (
    // supply level in millivolts
    input  wire logic [11:0] vdd_mv,
    // comparator outputs
    output logic             por_ok,
    output logic             above_reset,
    output logic             above_warning,
    // ring oscillator
    output logic             ring_osc
);
    // ==========================================================
    // threshold comparators, asynchronous to the system clock
    assign por_ok        = (vdd_mv > POR_MV[11:0]);
    assign above_reset   = (vdd_mv > RST_MV[11:0]);
    assign above_warning = (vdd_mv > WRN_MV[11:0]);
    // ==========================================================
    // free-running ring oscillator, sped up to keep runs short
    initial begin
        ring_osc = 1'b0;
        forever #(RING_NS / 2) ring_osc = ~ring_osc;
    end
endmodule // supply_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pwr_seq_pkg::*;
    localparam int WARM = 8;
    localparam int RING = 34;
    typedef struct {
        logic dis;
        logic warn_low;
        logic use_tmr;
    } stop_row_t;
    stop_row_t rows [3] = '{'{1'b1, 1'b1, 1'b0}, '{1'b0, 1'b1, 1'b0},
                            '{1'b1, 1'b0, 1'b1}};
    logic             sys_clk, rstn, ring_osc;
    logic             por_ok, above_reset, above_warning;
    logic             ext_reset_req, io_wake, stop_req;
    logic             mon_dis_wr, mon_dis_wdata, wake_timer_en;
    logic [TMR_W-1:0] wake_interval;
    logic [1:0]       monitor_interval_sel;
    logic             warning_int_en, warning_flag_clr;
    logic             stop_monitor_disable, supply_warning_flag;
    logic             warning_irq, cpu_reset, cpu_halt, monitor_on;
    logic             regulator_on, xtal_on, sram_retain;
    logic [15:0]      resume_addr;
    logic [11:0]      vdd_mv;
    int               errors, checks, cyc, n;
    // ==========================================================
    // clock, models and design
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    supply_model #(.RING_NS(RING)) i_supply (.vdd_mv(vdd_mv),
        .por_ok(por_ok), .above_reset(above_reset),
        .above_warning(above_warning), .ring_osc(ring_osc));
    pwr_sequencer #(.WARM_CYC(WARM)) i_dut (.sys_clk(sys_clk),
        .rstn(rstn), .por_ok(por_ok), .above_reset(above_reset),
        .above_warning(above_warning), .ring_osc(ring_osc),
        .ext_reset_req(ext_reset_req), .io_wake(io_wake),
        .stop_req(stop_req), .mon_dis_wr(mon_dis_wr),
        .mon_dis_wdata(mon_dis_wdata), .wake_timer_en(wake_timer_en),
        .wake_interval(wake_interval),
        .monitor_interval_sel(monitor_interval_sel),
        .warning_int_en(warning_int_en),
        .warning_flag_clr(warning_flag_clr),
        .stop_monitor_disable(stop_monitor_disable),
        .supply_warning_flag(supply_warning_flag),
        .warning_irq(warning_irq), .cpu_reset(cpu_reset),
        .cpu_halt(cpu_halt), .monitor_on(monitor_on),
        .regulator_on(regulator_on), .xtal_on(xtal_on),
        .sram_retain(sram_retain), .resume_addr(resume_addr));
    // ==========================================================
    // helpers
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // waits on cpu_halt (sel 0) or cpu_reset (sel 1)
    task automatic wait_out(input int sel, input logic val, input int lim);
        n = 0;
        while (n < lim && (sel == 0 ? cpu_halt : cpu_reset) !== val) begin
            tick(1);
            n++;
        end
    endtask
    task automatic enter_stop(input logic dis);
        mon_dis_wr = 1'b1;
        mon_dis_wdata = dis;
        warning_flag_clr = 1'b1;
        tick(1);
        mon_dis_wr = 1'b0;
        warning_flag_clr = 1'b0;
        stop_req = 1'b1;
        tick(1);
        stop_req = 1'b0;
        tick(2);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            $display("wrong value run_time expected end seen hang");
            summarize();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        {rstn, ext_reset_req, io_wake, stop_req, mon_dis_wr} = '0;
        {mon_dis_wdata, wake_timer_en, warning_int_en} = '0;
        warning_flag_clr = 1'b0;
        monitor_interval_sel = MON_ALWAYS;
        wake_interval = 16'h0004;
        vdd_mv = 12'h000;
        {errors, checks, cyc} = '0;
        tick(16);
        chk("stop_monitor_disable", 1, stop_monitor_disable);
        chk("regulator_on", 0, regulator_on);
        vdd_mv = 12'h640;
        rstn = 1'b1;
        tick(WARM + 6);
        chk("xtal_on", 1, xtal_on);
        chk("cpu_reset", 1, cpu_reset);
        vdd_mv = 12'h7d0;
        wait_out(1, 0, WARM + 10);
        chk("resume_addr", COLD_START_ADDR, resume_addr);
        for (int i = 0; i < 3; i++) begin
            wake_timer_en = rows[i].use_tmr;
            enter_stop(rows[i].dis);
            chk("cpu_halt", 1, cpu_halt);
            chk("monitor_on", !rows[i].dis, monitor_on);
            if (rows[i].warn_low) vdd_mv = 12'h708;
            if (rows[i].dis && !rows[i].use_tmr) begin
                tick(40);
                chk("cpu_halt", 1, cpu_halt);
                io_wake = 1'b1;
            end
            wait_out(0, 0, 400);
            io_wake = 1'b0;
            chk("cpu_halt", 0, cpu_halt);
            chk("monitor_on", 1, monitor_on);
            chk("flag", rows[i].warn_low, supply_warning_flag);
            chk("warning_irq", 0, warning_irq);
            if (rows[i].use_tmr) chk("timer_wait", 1, n >= 15);
            vdd_mv = 12'h7d0;
        end
        wake_timer_en = 1'b0;
        enter_stop(1'b1);
        vdd_mv = 12'h640;
        tick(40);
        chk("cpu_reset", 0, cpu_reset);
        io_wake = 1'b1;
        wait_out(1, 1, WARM + 20);
        io_wake = 1'b0;
        chk("cpu_reset", 1, cpu_reset);
        for (int s = 0; s < 3; s++) begin
            monitor_interval_sel = s[1:0];
            vdd_mv = 12'h640;
            tick(6);
            chk("cpu_reset", 1, cpu_reset);
            chk("regulator_on", 0, regulator_on);
            chk("sram_retain", 1, sram_retain);
            chk("monitor_on", s == 0, monitor_on);
            vdd_mv = 12'h7d0;
            wait_out(1, 0, 20000);
            chk("resume_addr", PF_RESUME_ADDR, resume_addr);
            chk("pf_wait", 1,
                n >= (s ? 1000 << s : 2) * RING / 8);
        end
        warning_int_en = 1'b1;
        vdd_mv = 12'h708;
        tick(WARN_PERSIST_CYC - 100);
        vdd_mv = 12'h7d0;
        tick(5);
        chk("flag", 0, supply_warning_flag);
        vdd_mv = 12'h708;
        tick(WARN_PERSIST_CYC + 10);
        chk("warning_irq", 1, warning_irq);
        chk("cpu_reset", 0, cpu_reset);
        vdd_mv = 12'h7d0;
        warning_flag_clr = 1'b1;
        tick(1);
        warning_flag_clr = 1'b0;
        tick(2);
        chk("flag", 0, supply_warning_flag);
        ext_reset_req = 1'b1;
        tick(6);
        chk("regulator_on", 1, regulator_on);
        chk("cpu_reset", 1, cpu_reset);
        ext_reset_req = 1'b0;
        wait_out(1, 0, RST_REL_CYC + 8);
        chk("cpu_reset", 0, cpu_reset);
        chk("release_time", 1, n < RST_REL_CYC);
        enter_stop(1'b1);
        vdd_mv = 12'h3e8;
        tick(6);
        chk("cpu_reset", 1, cpu_reset);
        chk("monitor_on", 0, monitor_on);
        vdd_mv = 12'h7d0;
        wait_out(1, 0, WARM + 20);
        chk("cpu_reset", 0, cpu_reset);
        chk("resume_addr", COLD_START_ADDR, resume_addr);
        enter_stop(1'b0);
        rstn = 1'b0;
        tick(2);
        chk("stop_monitor_disable", 1, stop_monitor_disable);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
